/* File: verif/etp_pin_model.sv */
// Behavioural source for the external count pin of the timer.
// Assumes one bench process calls its tasks; changes follow REF_CLK edges.
`timescale 1ns/1ps
module etp_pin_model
(
  input  wire logic clk,  // Bench clock
  output logic      pin   // Count pin level
);
  // Rests low so the first burst starts with a clean rising edge
  initial pin = 1'h0;

  // Drop low and settle, so an old high level cannot pass as a new edge
  task automatic park(input int half);
    @(posedge clk);
    pin <= 1'h0;
    repeat (2 * half) @(posedge clk);
  endtask

  // Makes n rising and n-1 falling edges; half sets the pace of the pulses
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      pin <= 1'h1;
      repeat (half) @(posedge clk);
      // The last pulse stays high, so the falling count is one short
      if (i < n - 1)
        pin <= 1'h0;
      repeat (half - 1) @(posedge clk);
    end
    repeat (2 * half) @(posedge clk);
  endtask
endmodule

/* File: verif/etp_timer_tb.sv */
// Self-checking bench for the eight-bit timer with its shared prescaler.
// Assumes the register port answers with no wait state, as handed over.
`timescale 1ns/1ps
module etp_timer_tb;
  // ************************************************************
  // Bench plumbing
  // ************************************************************
  logic        ref_clk = 1'h0;
  logic        srst = 1'h1;        // Held for six cycles at start
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;             // Slave ready looped back as bus ready
  logic        hresp;
  logic        pin;
  logic        sleep = 1'h0;
  logic        wdt_clear = 1'h0;
  logic        wdt_tick;
  logic        ovf_gate;
  logic        ovf_irq;
  logic        irq;
  logic [31:0] v1, v2, q, dc;
  logic [7:0]  opt;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;            // Cycles run, for the hang limit
  int          wdt_cnt = 0;        // Watchdog ticks seen
  int          gate_cnt = 0;       // Rollover pulses seen
  int          dw, n, g0;
  logic [7:0]  rs_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  logic [31:0] rs_v [6] = '{32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #4 ref_clk = ~ref_clk;

  etp_timer dut
  (
    .REF_CLK(ref_clk), .SRST(srst), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .EXTERNAL_COUNT_PIN(pin),
    .SLEEP(sleep), .WDT_CLEAR(wdt_clear), .WDT_TICK(wdt_tick),
    .OVF_GATE(ovf_gate), .OVF_IRQ(ovf_irq), .IRQ(irq)
  );

  etp_pin_model pm (.clk(ref_clk), .pin(pin));

  // Pulse counters use non-blocking updates so bench reads never race them
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (wdt_tick === 1'h1)
      wdt_cnt <= wdt_cnt + 1;
    if (ovf_gate === 1'h1)
      gate_cnt <= gate_cnt + 1;
    // Well above the roughly 13400 cycles the run needs
    if (cyc == 60000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  // One single transfer; waits on ready, whatever the latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'h1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'h1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'h0, a, 32'h0, r);
  endtask

  // Count and tick growth over exactly d clocks between two reads
  task automatic measure(input int d, output logic [31:0] c, output int t);
    int w0;
    rd(etp_pkg::OFS_COUNT, v1);
    w0 = wdt_cnt;
    repeat (d - 3) @(posedge ref_clk);
    rd(etp_pkg::OFS_COUNT, v2);
    c = (v2 - v1) & 32'hFF;
    t = wdt_cnt - w0;
  endtask

  // Timer steps in d clocks: four clocks per cycle, then the prescaler
  function automatic logic [31:0] exp_timer(input logic [7:0] o, input int d);
    int ticks;
    ticks = d / 4;
    if (o[3] === 1'h0)
      ticks = ticks / (2 << o[2:0]);
    return 32'(ticks) & 32'hFF;
  endfunction

  function automatic int exp_wdt(input logic [7:0] o, input int d);
    return (d / 4) >> o[2:0];
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    v1 = $urandom(32'h110417FF);
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
    // Reset contents; a write to a hole must leave no trace
    wr(8'h20, 32'h5A);
    for (int i = 0; i < 6; i++)
    begin
      rd(rs_a[i], q);
      check(q, rs_v[i]);
    end
    check({31'h0, hresp}, 32'h0);
    // Every rate code with the prescaler on the timer
    for (int r = 0; r < 8; r++)
    begin
      opt = {5'h00, r[2:0]};
      wr(etp_pkg::OFS_OPTION, {24'h0, opt});
      measure(16 * (2 << r), dc, dw);
      check(dc, exp_timer(opt, 16 * (2 << r)));
    end
    // Prescaler on the watchdog: timer undivided, watchdog divided
    for (int r = 0; r < 8; r++)
    begin
      opt = {5'h01, r[2:0]};
      wr(etp_pkg::OFS_OPTION, {24'h0, opt});
      measure(16 << r, dc, dw);
      check(dc, exp_timer(opt, 16 << r));
      check(32'(dw), 32'(exp_wdt(opt, 16 << r)));
    end
    // Frequent watchdog clears keep a 1:4 prescaler from ever ticking
    wr(etp_pkg::OFS_OPTION, 32'h0A);
    @(posedge ref_clk);
    wdt_clear <= 1'h1;
    @(posedge ref_clk);
    wdt_clear <= 1'h0;
    repeat (2) @(posedge ref_clk);
    g0 = wdt_cnt;
    repeat (20)
    begin
      @(posedge ref_clk);
      wdt_clear <= 1'h1;
      @(posedge ref_clk);
      wdt_clear <= 1'h0;
      repeat (6) @(posedge ref_clk);
    end
    check(32'(wdt_cnt - g0), 32'h0);
    // Sleep freezes the count and the prescaler
    wr(etp_pkg::OFS_OPTION, 32'h08);
    @(posedge ref_clk);
    sleep <= 1'h1;
    measure(40, dc, dw);
    check(dc, 32'h0);
    check(32'(dw), 32'h0);
    @(posedge ref_clk);
    sleep <= 1'h0;
    // Random count writes: the first two cycles after each are lost
    repeat (4)
    begin
      q = $urandom & 32'hFF;
      wr(etp_pkg::OFS_COUNT, q);
      repeat (39) @(posedge ref_clk);
      rd(etp_pkg::OFS_COUNT, v2);
      check(v2, (q + exp_timer(8'h08, 40) - 32'h2) & 32'hFF);
    end
    // Back-to-back count writes land inside the blanking time
    wr(etp_pkg::OFS_IRQ_CLR, 32'h3);
    wr(etp_pkg::OFS_COUNT, 32'h0);
    wr(etp_pkg::OFS_COUNT, 32'h0);
    rd(etp_pkg::OFS_IRQ_CLR, q);
    check(q, 32'h2);
    // Rollover with both enables off, then on, then cleared by software
    wr(etp_pkg::OFS_INTCTL, 32'h0);
    wr(etp_pkg::OFS_IRQ_CLR, 32'h3);
    g0 = gate_cnt;
    wr(etp_pkg::OFS_COUNT, 32'hFC);
    repeat (40) @(posedge ref_clk);
    check(32'(gate_cnt - g0), 32'h1);
    rd(etp_pkg::OFS_INTCTL, q);
    check(q, 32'h04);
    check({31'h0, ovf_irq}, 32'h0);
    rd(etp_pkg::OFS_IRQ_CLR, q);
    check(q, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(etp_pkg::OFS_INTCTL, 32'h24);
    wr(etp_pkg::OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, ovf_irq}, 32'h1);
    check({31'h0, irq}, 32'h1);
    repeat (100) @(posedge ref_clk);
    rd(etp_pkg::OFS_INTCTL, q);
    check(q, 32'h24);
    wr(etp_pkg::OFS_IRQ_CLR, 32'h1);
    rd(etp_pkg::OFS_IRQ_CLR, q);
    check(q, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(etp_pkg::OFS_INTCTL, 32'h20);
    @(posedge ref_clk);
    check({31'h0, ovf_irq}, 32'h0);
    // Pin counting on each edge, with a quick and a slow source
    for (int e = 0; e < 2; e++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        opt = {3'h1, e[0], 4'h8};
        wr(etp_pkg::OFS_OPTION, {24'h0, opt});
        n = 2 + ($urandom % 8);
        pm.park(4 + 4 * s);
        rd(etp_pkg::OFS_COUNT, v1);
        pm.burst(n, 4 + 4 * s);
        rd(etp_pkg::OFS_COUNT, v2);
        check((v2 - v1) & 32'hFF, 32'(n - e));
      end
    end
    summarize();
  end
endmodule

/* File: verilog/etp_pkg.sv */
// Constants, field layouts and carrier types for the 8-bit timer block.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
// What this block does
// - Eight-bit count register, timer or counter
// - Timer mode without prescaler counts each cycle
// - Write to count blocks two instruction cycles
// - Option bit 5 selects pin or instruction clock
// - Option bit 4 selects falling or rising edge
// - Option bit 3 gives prescaler to watchdog
// - Rate field divides timer 1:2 to 1:256
// - Watchdog assignment: timer undivided, watchdog 1:1..1:128
// - Prescaler hidden; count write clears it while assigned to timer
// - Watchdog clear also clears assigned prescaler
// - Every rollover sets the overflow flag
// - Only software clears the overflow flag
// - Overflow interrupt gated by enable bit
// - Timer frozen while in sleep
// - Pin edge sampled on Q2 and Q4
// - Overflow indication offered to gate logic
// - Rollover gives a rising pulse to gate
package etp_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_OPTION  = 8'h00; // timer_option_control
  localparam logic [7:0] OFS_INTCTL  = 8'h04; // interrupt_control
  localparam logic [7:0] OFS_COUNT   = 8'h08; // timer_count_value
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0C; // write-one-to-clear status
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10; // same layout, enable

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int          B_SRC      = 5;     // count_source_select
  localparam int          B_EDGE     = 4;     // count_edge_select
  localparam int          B_PSA      = 3;     // prescaler_assign
  localparam int          B_FLAG     = 2;     // overflow_flag in interrupt_control
  localparam int          B_IE       = 5;     // overflow_irq_enable
  localparam logic [7:0]  OPT_RST    = 8'hFF;
  localparam logic [7:0]  ZERO8      = 8'h00;
  localparam logic [7:0]  ONE8       = 8'h01;
  localparam logic [1:0]  BLANK_CYC  = 2'h2;  // cycles suppressed after a write
  localparam logic [1:0]  Q_LAST     = 2'h3;  // four Q phases per instruction

  // Status bits for the interrupt status block
  localparam int          S_OVF      = 0;
  localparam int          S_WRAP     = 1;     // write landed during blanking

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed
  {
    logic       pull_up_n;  // kept for software only
    logic       int_edge;   // kept for software only
    logic       src_pin;
    logic       edge_fall;
    logic       psa_wdt;
    logic [2:0] rate;
  } etp_option_t;

  typedef enum logic [3:0]
  {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } etp_phase_t;

endpackage

/* File: verilog/etp_timer.sv */
// Eight-bit timer/counter with a prescaler shared with the watchdog.
// Assumes the CPU core drives sleep and watchdog-clear as plain levels
// and that the external count pin is already synchronous to REF_CLK.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module etp_timer
(
  input  wire logic        REF_CLK,      // 125 MHz clock
  input  wire logic        SRST,         // Synchronous reset, active high
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        EXTERNAL_COUNT_PIN,
  input  wire logic        SLEEP,        // Core is asleep
  input  wire logic        WDT_CLEAR,    // Watchdog clear instruction pulse
  output logic             WDT_TICK,     // Prescaled watchdog tick
  output logic             OVF_GATE,     // Rollover pulse to 16-bit gate
  output logic             OVF_IRQ,      // Overflow flag and enable
  output logic             IRQ           // Status block interrupt
);

  // ************************************************************
  // Registers
  // ************************************************************
  etp_pkg::etp_option_t opt_r;       // timer_option_control
  etp_pkg::etp_phase_t  phase_r;     // Q-phase sequencer
  logic [7:0]           count_r;     // timer_count_value
  logic [7:0]           intctl_r;    // interrupt_control, flag hardware set
  logic [7:0]           pre_r;       // Hidden prescaler counter
  logic [1:0]           blank_r;     // Instruction cycles still suppressed
  logic                 pin_q2_r;    // Pin sampled on Q2
  logic                 pin_q4_r;    // Pin sampled on Q4
  logic [1:0]           sts_r;       // Sticky status
  logic [1:0]           en_r;        // Status enables
  logic                 aw_r;        // Pending write data phase
  logic                 ar_r;        // Pending read data phase
  logic [7:0]           addr_r;      // Latched address
  logic                 gate_r;      // Gate pulse register

  // ************************************************************
  // Combinational helpers
  // ************************************************************
  logic       inst_tick;    // One per instruction cycle
  logic       edge_ev;      // Selected pin edge, on sampling phase
  logic       src_ev;       // Raw event to prescaler or count
  logic       pre_out;      // Prescaler output for the timer
  logic       count_ev;     // Final increment
  logic       wr_count;     // Software write to count register
  logic       wr_intctl;
  logic       wdt_ev;       // Watchdog-side tick
  logic       rollover;

  // Divider terminal for a rate code: 2^(code+1) for timer, 2^code for wdt.
  // Compared with >= so that a count left high by a coarser rate or by the
  // other owner ends the period at once instead of wrapping through 256.
  function automatic logic pre_hit(input logic [7:0] cnt, input logic [2:0] rate,
                                   input logic wdt);
    logic [3:0] sh;
    logic [8:0] lim;
    sh  = wdt ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
    lim = 9'h001 << sh;
    pre_hit = ({1'b0, cnt} + 9'h001) >= lim;
  endfunction

  // Instruction tick lands at end of Q4; the phase stands still in sleep,
  // so the tick is masked there or it would stay high for the whole sleep
  assign inst_tick = (phase_r == etp_pkg::Q4) && !SLEEP;
  // New sample against the latest stored one: Q4 sample at Q2, Q2 at Q4
  assign edge_ev   = !SLEEP &&
                     (((phase_r == etp_pkg::Q2) &&
                       (opt_r.edge_fall ? (pin_q4_r & ~EXTERNAL_COUNT_PIN)
                                        : (~pin_q4_r & EXTERNAL_COUNT_PIN))) ||
                      ((phase_r == etp_pkg::Q4) &&
                       (opt_r.edge_fall ? (pin_q2_r & ~EXTERNAL_COUNT_PIN)
                                        : (~pin_q2_r & EXTERNAL_COUNT_PIN))));
  assign src_ev    = opt_r.src_pin ? edge_ev : inst_tick;
  assign pre_out   = src_ev && pre_hit(pre_r, opt_r.rate, 1'b0);
  // Prescaler only in the timer path when assigned to it
  assign count_ev  = !SLEEP && (blank_r == 2'h0) &&
                     (opt_r.psa_wdt ? src_ev : pre_out);
  assign wdt_ev    = inst_tick && opt_r.psa_wdt &&
                     pre_hit(pre_r, opt_r.rate, 1'b1);
  assign rollover  = count_ev && (count_r == 8'hFF);
  assign wr_count  = aw_r && (addr_r == etp_pkg::OFS_COUNT);
  assign wr_intctl = aw_r && (addr_r == etp_pkg::OFS_INTCTL);

  // ************************************************************
  // Q-phase sequencer, frozen in sleep
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      phase_r <= etp_pkg::Q1;
    else if (!SLEEP)
    begin
      case (phase_r)
        etp_pkg::Q1: phase_r <= etp_pkg::Q2;
        etp_pkg::Q2: phase_r <= etp_pkg::Q3;
        etp_pkg::Q3: phase_r <= etp_pkg::Q4;
        etp_pkg::Q4: phase_r <= etp_pkg::Q1;
        default:     phase_r <= etp_pkg::Q1;
      endcase
    end
  end

  // Pin samples on Q2 and Q4
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pin_q2_r <= 1'b0;
      pin_q4_r <= 1'b0;
    end
    else
    begin
      if (phase_r == etp_pkg::Q2)
        pin_q2_r <= EXTERNAL_COUNT_PIN;
      if (phase_r == etp_pkg::Q4)
        pin_q4_r <= EXTERNAL_COUNT_PIN;
    end
  end

  // ************************************************************
  // Prescaler: invisible to software
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      pre_r <= etp_pkg::ZERO8;
    else if (wr_count && !opt_r.psa_wdt)
      pre_r <= etp_pkg::ZERO8;
    else if (WDT_CLEAR && opt_r.psa_wdt)
      pre_r <= etp_pkg::ZERO8;
    else if (!opt_r.psa_wdt && pre_out)
      pre_r <= etp_pkg::ZERO8;
    else if (opt_r.psa_wdt && wdt_ev)
      pre_r <= etp_pkg::ZERO8;
    else if (!SLEEP && (opt_r.psa_wdt ? inst_tick : src_ev))
      pre_r <= pre_r + etp_pkg::ONE8;
  end

  // ************************************************************
  // Count register and write blanking
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      count_r <= etp_pkg::ZERO8;
    else if (wr_count)
      count_r <= HWDATA[7:0];
    else if (count_ev)
      count_r <= count_r + etp_pkg::ONE8;
  end

  // Blanking counts instruction ticks, not clocks
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      blank_r <= 2'h0;
    else if (wr_count)
      blank_r <= etp_pkg::BLANK_CYC;
    else if (inst_tick && !SLEEP && (blank_r != 2'h0))
      blank_r <= blank_r - 2'h1;
  end

  // ************************************************************
  // Option and interrupt control
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      opt_r <= etp_pkg::OPT_RST;
    else if (aw_r && (addr_r == etp_pkg::OFS_OPTION))
      opt_r <= HWDATA[7:0];
  end

  // Hardware only sets the flag; a set in the write cycle wins
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      intctl_r <= etp_pkg::ZERO8;
    else
    begin
      if (wr_intctl)
        intctl_r <= HWDATA[7:0];
      if (rollover)
        intctl_r[etp_pkg::B_FLAG] <= 1'b1;
    end
  end

  assign OVF_IRQ = intctl_r[etp_pkg::B_FLAG] && intctl_r[etp_pkg::B_IE];

  // Gate pulse, one clock wide from a register
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      gate_r <= 1'b0;
    else
      gate_r <= rollover;
  end

  assign OVF_GATE = gate_r;
  assign WDT_TICK = wdt_ev;

  // ************************************************************
  // Status block: sticky, clear by write-one, level interrupt
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      sts_r <= 2'h0;
    else
      sts_r <= (sts_r & ~((aw_r && addr_r == etp_pkg::OFS_IRQ_CLR) ? HWDATA[1:0] : 2'h0))
               | {wr_count && (blank_r != 2'h0), rollover};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      en_r <= 2'h0;
    else if (aw_r && (addr_r == etp_pkg::OFS_IRQ_EN))
      en_r <= HWDATA[1:0];
  end

  assign IRQ = |(sts_r & en_r);

  // ************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      aw_r   <= 1'b0;
      ar_r   <= 1'b0;
      addr_r <= etp_pkg::ZERO8;
    end
    else if (HREADY)
    begin
      aw_r   <= HSEL && HTRANS[1] && HWRITE;
      ar_r   <= HSEL && HTRANS[1] && !HWRITE;
      addr_r <= HADDR;
    end
    else
    begin
      aw_r <= 1'b0;
      ar_r <= 1'b0;
    end
  end

  // Read data is registered at the address phase so it stands in data phase
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      HRDATA <= 32'h0000_0000;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
    begin
      case (HADDR)
        etp_pkg::OFS_OPTION:  HRDATA <= {24'h000000, opt_r};
        etp_pkg::OFS_INTCTL:  HRDATA <= {24'h000000, intctl_r};
        etp_pkg::OFS_COUNT:   HRDATA <= {24'h000000, count_r};
        etp_pkg::OFS_IRQ_CLR: HRDATA <= {30'h00000000, sts_r};
        etp_pkg::OFS_IRQ_EN:  HRDATA <= {30'h00000000, en_r};
        default:              HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ************************************************************
  // Checks
  // ************************************************************
  a_flag_sets: assert property (@(posedge REF_CLK) disable iff (SRST)
    rollover |=> intctl_r[etp_pkg::B_FLAG])
    else $error("overflow flag not set on rollover");
  a_flag_holds: assert property (@(posedge REF_CLK) disable iff (SRST)
    intctl_r[etp_pkg::B_FLAG] && !wr_intctl |=> intctl_r[etp_pkg::B_FLAG])
    else $error("overflow flag cleared by hardware");
  a_blank_count: assert property (@(posedge REF_CLK) disable iff (SRST)
    wr_count |=> !count_ev throughout (blank_r != 2'h0))
    else $error("count advanced during write blanking");
  a_sleep_freeze: assert property (@(posedge REF_CLK) disable iff (SRST)
    SLEEP && !wr_count |=> count_r == $past(count_r))
    else $error("count moved in sleep");
  a_gate_pulse: assert property (@(posedge REF_CLK) disable iff (SRST)
    rollover |=> OVF_GATE ##1 !OVF_GATE)
    else $error("gate pulse wrong");
  a_irq_level: assert property (@(posedge REF_CLK) disable iff (SRST)
    OVF_IRQ == (intctl_r[etp_pkg::B_FLAG] && intctl_r[etp_pkg::B_IE]))
    else $error("interrupt output mismatch");
  a_pre_clear: assert property (@(posedge REF_CLK) disable iff (SRST)
    wr_count && !opt_r.psa_wdt |=> pre_r == etp_pkg::ZERO8)
    else $error("prescaler not cleared by count write");
  a_wdt_clear: assert property (@(posedge REF_CLK) disable iff (SRST)
    WDT_CLEAR && opt_r.psa_wdt && !wr_count |=> pre_r == etp_pkg::ZERO8)
    else $error("prescaler not cleared by watchdog clear");
  a_undivided: assert property (@(posedge REF_CLK) disable iff (SRST)
    opt_r.psa_wdt && !opt_r.src_pin && inst_tick && !SLEEP && blank_r == 2'h0 && !wr_count
    |=> count_r == $past(count_r) + etp_pkg::ONE8)
    else $error("timer mode did not advance");

endmodule
